// >>> mac_filt_pkg.sv
// constants, field layout and state types for the station address filter and phy management
// Functional notes
// - upper address register, bits 47..32, resets ones
// - lower address register, bits 31..0, resets ones
// - lower byte zero compared against first octet
// - address registers obey reset protection setting
// - hash index msb picks word, rest bit
// - selected hash bit one accepts group frame
// - accept-all-group setting accepts every group frame
// - hash table two read-write words, reset zero
// - index field 10..6 picks phy register
// - bit 1 selects write, zero selects read
// - read result lands in data register on the edge that clears pending
// - pending bit set starts, hardware clears at end
// - data held during write, invalid during read
// - data register sixteen bits, reset zero
package mac_filt_pkg;
    // register offsets (byte addresses)
    localparam logic [11:0] OFS_STATION_UPPER = 12'h104;
    localparam logic [11:0] OFS_STATION_LOWER = 12'h108;
    localparam logic [11:0] OFS_HASH_UPPER = 12'h10C;
    localparam logic [11:0] OFS_HASH_LOWER = 12'h110;
    localparam logic [11:0] OFS_MGMT_CTRL = 12'h114;
    localparam logic [11:0] OFS_MGMT_DATA = 12'h118;
    localparam logic [11:0] OFS_FILTER_CTRL = 12'h180;
    // reset values
    localparam logic [15:0] STATION_UPPER_RST = 16'hFFFF;
    localparam logic [31:0] STATION_LOWER_RST = 32'hFFFF_FFFF;
    localparam logic [31:0] HASH_RST = 32'h0000_0000;
    localparam logic [15:0] MGMT_DATA_RST = 16'h0000;
    // management control fields
    localparam int CTL_PEND_BIT = 0;
    localparam int CTL_WRITE_BIT = 1;
    localparam int CTL_INDEX_LSB = 6;
    localparam int CTL_PHYADDR_LSB = 11;
    localparam int FIELD_W = 5;
    localparam int FILT_ACCEPT_ALL_BIT = 0;
    // filter constants
    localparam logic [31:0] CRC_POLY = 32'hEDB8_8320;
    localparam logic [31:0] CRC_INIT = 32'hFFFF_FFFF;
    localparam logic [2:0] ADDR_OCTETS = 3'h6;
    localparam int HASH_IDX_W = 6;
    // management sequencer states
    typedef enum logic {MGMT_IDLE, MGMT_BUSY} mgmt_state_t;
endpackage : mac_filt_pkg

// >>> filt_if.sv
// interface carrying filter settings and verdicts between the register block and the filter
interface filt_if;
    logic [47:0] station_addr; // {upper[15:0], lower[31:0]}
    logic [63:0] hash_table; // {upper word, lower word}
    logic accept_all; // pass every group frame
    logic verdict_valid; // one-cycle pulse after the sixth octet
    logic station_hit; // destination equals station address
    logic group_frame; // destination is a group address
    logic group_accept; // group frame passes hash or accept-all
    modport ctl (
        output station_addr, hash_table, accept_all,
        input verdict_valid, station_hit, group_frame, group_accept
    );
    modport flt (
        input station_addr, hash_table, accept_all,
        output verdict_valid, station_hit, group_frame, group_accept
    );
endinterface : filt_if

// >>> addr_filter.sv
// destination address filter: station compare and multicast hash lookup
module addr_filter (
    // clock and synchronised reset
    input wire logic clk_i,
    input wire logic rst_n_i,
    // destination octets from the receiver
    input wire logic rx_start_i,
    input wire logic rx_valid_i,
    input wire logic [7:0] rx_byte_i,
    // settings in, verdicts out
    filt_if.flt fif
);
    logic [2:0] cnt_reg, cnt_next; // octets seen in this frame
    logic [31:0] crc_reg, crc_next; // running crc over the destination
    logic hit_reg, hit_next; // all octets so far match
    logic grp_reg, grp_next; // first octet group bit
    logic vld_reg, vld_next;
    logic acc_reg, acc_next;
    logic [5:0] idx_reg, idx_next; // hash index kept for checking
    logic [2:0] pos; // octet position of the current byte
    logic [31:0] crc_step;
    logic hit_step;

    // one octet of reflected crc-32, lsb first as on the wire
    function automatic logic [31:0] crc_byte(input logic [31:0] c, input logic [7:0] d);
        logic [31:0] r;
        r = c;
        for (int i = 0; i < 8; i++) begin
            if (r[0] ^ d[i]) begin
                r = (r >> 1) ^ mac_filt_pkg::CRC_POLY;
            end else begin
                r = r >> 1;
            end
        end
        return r;
    endfunction : crc_byte

    // a start octet restarts the count so a runt frame never poisons the next
    always_comb begin
        pos = rx_start_i ? 3'h0 : cnt_reg;
        crc_step = crc_byte(rx_start_i ? mac_filt_pkg::CRC_INIT : crc_reg, rx_byte_i);
        hit_step = (rx_start_i || hit_reg) &&
                   (rx_byte_i == fif.station_addr[{pos, 3'h0} +: 8]);
        cnt_next = cnt_reg;
        crc_next = crc_reg;
        hit_next = hit_reg;
        grp_next = grp_reg;
        idx_next = idx_reg;
        vld_next = 1'b0;
        acc_next = acc_reg;
        if (rx_valid_i && (pos < mac_filt_pkg::ADDR_OCTETS)) begin
            cnt_next = pos + 3'h1;
            crc_next = crc_step;
            hit_next = hit_step;
            if (pos == 3'h0) begin
                grp_next = rx_byte_i[0];
            end
            if (pos == mac_filt_pkg::ADDR_OCTETS - 3'h1) begin
                // upper six crc bits; msb picks the word, the rest the bit
                idx_next = crc_step[31 -: mac_filt_pkg::HASH_IDX_W];
                acc_next = fif.accept_all || fif.hash_table[idx_next];
                vld_next = 1'b1;
            end
        end
    end

    // filter state registers
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            cnt_reg <= 3'h0;
            crc_reg <= mac_filt_pkg::CRC_INIT;
            hit_reg <= 1'b0;
            grp_reg <= 1'b0;
            idx_reg <= 6'h00;
            vld_reg <= 1'b0;
            acc_reg <= 1'b0;
        end else begin
            cnt_reg <= cnt_next;
            crc_reg <= crc_next;
            hit_reg <= hit_next;
            grp_reg <= grp_next;
            idx_reg <= idx_next;
            vld_reg <= vld_next;
            acc_reg <= acc_next;
        end
    end

    assign fif.verdict_valid = vld_reg;
    assign fif.station_hit = hit_reg;
    assign fif.group_frame = grp_reg;
    assign fif.group_accept = acc_reg;

    // verdict reflects accept-all or the indexed hash bit
    group_accept_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        vld_reg && $stable(fif.hash_table) && $stable(fif.accept_all) |->
            acc_reg == (fif.accept_all || fif.hash_table[idx_reg]))
        else $error("group verdict does not follow hash table");
    accept_all_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        vld_reg && $past(fif.accept_all) |-> acc_reg)
        else $error("accept-all did not pass group frame");
endmodule : addr_filter

// >>> mac_addr_filter_phy_mgmt.sv
// register block: station address, group hash table, filter control and phy management
module mac_addr_filter_phy_mgmt #(
    parameter int ADDR_W = 12 // register port address width
) (
    // clock and reset
    input wire logic core_clk_i,
    input wire logic rst_n_i,
    // register port
    input wire logic [ADDR_W-1:0] reg_addr_i,
    input wire logic [31:0] reg_wdata_i,
    input wire logic reg_wr_i,
    input wire logic reg_rd_i,
    output logic [31:0] reg_rdata_o,
    // soft reset and reset protection
    input wire logic soft_reset_i,
    input wire logic reset_protect_i,
    // receive destination octets
    input wire logic rx_start_i,
    input wire logic rx_valid_i,
    input wire logic [7:0] rx_byte_i,
    // filter verdicts and the station address
    output logic verdict_valid_o,
    output logic station_hit_o,
    output logic group_frame_o,
    output logic group_accept_o,
    output logic [47:0] station_addr_o,
    // internal phy management port
    output logic phy_req_o,
    output logic phy_write_o,
    output logic [4:0] phy_addr_o,
    output logic [4:0] phy_reg_o,
    output logic [15:0] phy_wdata_o,
    input wire logic phy_done_i,
    input wire logic [15:0] phy_rdata_i
);
    // the offsets need at least nine address bits
    if (ADDR_W < 9) begin : g_bad_addr_w
        $error("ADDR_W too small for the register map");
    end

    logic rst_meta_reg; // first synchroniser stage, read only by the second
    logic rst_sync_reg; // released reset used by the whole design
    logic rst_n;

    // reset release through two flip-flops; assertion stays asynchronous
    always_ff @(posedge core_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            rst_meta_reg <= 1'b0;
            rst_sync_reg <= 1'b0;
        end else begin
            rst_meta_reg <= 1'b1;
            rst_sync_reg <= rst_meta_reg;
        end
    end
    assign rst_n = rst_sync_reg;

    default clocking @(posedge core_clk_i);
    endclocking
    default disable iff (!rst_n);

    // address decode
    logic sel_st_up, sel_st_lo, sel_hash_up, sel_hash_lo;
    logic sel_ctl, sel_data, sel_filt;
    assign sel_st_up = (reg_addr_i == ADDR_W'(mac_filt_pkg::OFS_STATION_UPPER));
    assign sel_st_lo = (reg_addr_i == ADDR_W'(mac_filt_pkg::OFS_STATION_LOWER));
    assign sel_hash_up = (reg_addr_i == ADDR_W'(mac_filt_pkg::OFS_HASH_UPPER));
    assign sel_hash_lo = (reg_addr_i == ADDR_W'(mac_filt_pkg::OFS_HASH_LOWER));
    assign sel_ctl = (reg_addr_i == ADDR_W'(mac_filt_pkg::OFS_MGMT_CTRL));
    assign sel_data = (reg_addr_i == ADDR_W'(mac_filt_pkg::OFS_MGMT_DATA));
    assign sel_filt = (reg_addr_i == ADDR_W'(mac_filt_pkg::OFS_FILTER_CTRL));

    // filter settings group
    logic [15:0] st_upper_reg, st_upper_next; // address bits 47..32
    logic [31:0] st_lower_reg, st_lower_next; // address bits 31..0
    logic [31:0] hash_upper_reg, hash_upper_next;
    logic [31:0] hash_lower_reg, hash_lower_next;
    logic accept_all_reg, accept_all_next; // pass every group frame

    // next values of the filter settings
    always_comb begin
        st_upper_next = st_upper_reg;
        st_lower_next = st_lower_reg;
        hash_upper_next = hash_upper_reg;
        hash_lower_next = hash_lower_reg;
        accept_all_next = accept_all_reg;
        if (reg_wr_i && sel_st_up) begin
            st_upper_next = reg_wdata_i[15:0];
        end
        if (reg_wr_i && sel_st_lo) begin
            st_lower_next = reg_wdata_i;
        end
        if (reg_wr_i && sel_hash_up) begin
            hash_upper_next = reg_wdata_i;
        end
        if (reg_wr_i && sel_hash_lo) begin
            hash_lower_next = reg_wdata_i;
        end
        if (reg_wr_i && sel_filt) begin
            accept_all_next = reg_wdata_i[mac_filt_pkg::FILT_ACCEPT_ALL_BIT];
        end
        // soft reset wins over a same-cycle write except to a protected address; protection keeps the address
        if (soft_reset_i) begin
            hash_upper_next = mac_filt_pkg::HASH_RST;
            hash_lower_next = mac_filt_pkg::HASH_RST;
            accept_all_next = 1'b0;
            if (!reset_protect_i) begin
                st_upper_next = mac_filt_pkg::STATION_UPPER_RST;
                st_lower_next = mac_filt_pkg::STATION_LOWER_RST;
            end
        end
    end

    // filter settings registers
    always_ff @(posedge core_clk_i or negedge rst_n) begin
        if (!rst_n) begin
            st_upper_reg <= mac_filt_pkg::STATION_UPPER_RST;
            st_lower_reg <= mac_filt_pkg::STATION_LOWER_RST;
            hash_upper_reg <= mac_filt_pkg::HASH_RST;
            hash_lower_reg <= mac_filt_pkg::HASH_RST;
            accept_all_reg <= 1'b0;
        end else begin
            st_upper_reg <= st_upper_next;
            st_lower_reg <= st_lower_next;
            hash_upper_reg <= hash_upper_next;
            hash_lower_reg <= hash_lower_next;
            accept_all_reg <= accept_all_next;
        end
    end

    // management group
    mac_filt_pkg::mgmt_state_t state_reg, state_next;
    logic pending_reg, pending_next; // access in progress
    logic write_sel_reg, write_sel_next; // one: write, zero: read
    logic [4:0] phy_addr_reg, phy_addr_next; // phy address field, forwarded as written
    logic [4:0] phy_index_reg, phy_index_next; // phy register index
    logic [15:0] mgmt_data_reg, mgmt_data_next; // data to or from the phy

    // writes while pending are dropped so the running cycle keeps its
    // address, direction and data; software is expected to poll first
    always_comb begin
        state_next = state_reg;
        pending_next = pending_reg;
        write_sel_next = write_sel_reg;
        phy_addr_next = phy_addr_reg;
        phy_index_next = phy_index_reg;
        mgmt_data_next = mgmt_data_reg;
        case (state_reg)
            mac_filt_pkg::MGMT_IDLE: begin
                if (reg_wr_i && sel_data) begin
                    mgmt_data_next = reg_wdata_i[15:0];
                end
                if (reg_wr_i && sel_ctl) begin
                    phy_addr_next = reg_wdata_i[mac_filt_pkg::CTL_PHYADDR_LSB +:
                                                mac_filt_pkg::FIELD_W];
                    phy_index_next = reg_wdata_i[mac_filt_pkg::CTL_INDEX_LSB +:
                                                 mac_filt_pkg::FIELD_W];
                    write_sel_next = reg_wdata_i[mac_filt_pkg::CTL_WRITE_BIT];
                    if (reg_wdata_i[mac_filt_pkg::CTL_PEND_BIT]) begin
                        pending_next = 1'b1;
                        state_next = mac_filt_pkg::MGMT_BUSY;
                    end
                end
            end
            mac_filt_pkg::MGMT_BUSY: begin
                // request held until the phy answers
                if (phy_done_i) begin
                    pending_next = 1'b0;
                    state_next = mac_filt_pkg::MGMT_IDLE;
                    if (!write_sel_reg) begin
                        mgmt_data_next = phy_rdata_i;
                    end
                end
            end
            default: begin
                state_next = mac_filt_pkg::MGMT_IDLE;
                pending_next = 1'b0;
            end
        endcase
    end

    // management registers
    always_ff @(posedge core_clk_i or negedge rst_n) begin
        if (!rst_n) begin
            state_reg <= mac_filt_pkg::MGMT_IDLE;
            pending_reg <= 1'b0;
            write_sel_reg <= 1'b0;
            phy_addr_reg <= 5'h00;
            phy_index_reg <= 5'h00;
            mgmt_data_reg <= mac_filt_pkg::MGMT_DATA_RST;
        end else begin
            state_reg <= state_next;
            pending_reg <= pending_next;
            write_sel_reg <= write_sel_next;
            phy_addr_reg <= phy_addr_next;
            phy_index_reg <= phy_index_next;
            mgmt_data_reg <= mgmt_data_next;
        end
    end

    // read data group
    logic [31:0] rdata_reg, rdata_next;

    // read data stand only in the cycle after the strobe; unmapped reads zero
    always_comb begin
        rdata_next = 32'h0000_0000;
        if (reg_rd_i) begin
            if (sel_st_up) begin
                rdata_next = {16'h0000, st_upper_reg};
            end else if (sel_st_lo) begin
                rdata_next = st_lower_reg;
            end else if (sel_hash_up) begin
                rdata_next = hash_upper_reg;
            end else if (sel_hash_lo) begin
                rdata_next = hash_lower_reg;
            end else if (sel_ctl) begin
                rdata_next = {16'h0000, phy_addr_reg, phy_index_reg, 4'h0,
                              write_sel_reg, pending_reg};
            end else if (sel_data) begin
                rdata_next = {16'h0000, mgmt_data_reg};
            end else if (sel_filt) begin
                rdata_next = {31'h0000_0000, accept_all_reg};
            end
        end
    end

    // read data register
    always_ff @(posedge core_clk_i or negedge rst_n) begin
        if (!rst_n) begin
            rdata_reg <= 32'h0000_0000;
        end else begin
            rdata_reg <= rdata_next;
        end
    end

    // filter instance over the carrier interface
    filt_if fif ();
    assign fif.station_addr = {st_upper_reg, st_lower_reg};
    assign fif.hash_table = {hash_upper_reg, hash_lower_reg};
    assign fif.accept_all = accept_all_reg;

    addr_filter u_filter (
        .clk_i(core_clk_i),
        .rst_n_i(rst_n),
        .rx_start_i(rx_start_i),
        .rx_valid_i(rx_valid_i),
        .rx_byte_i(rx_byte_i),
        .fif(fif.flt)
    );

    // outputs, all from flip-flops
    assign reg_rdata_o = rdata_reg;
    assign verdict_valid_o = fif.verdict_valid;
    assign station_hit_o = fif.station_hit;
    assign group_frame_o = fif.group_frame;
    assign group_accept_o = fif.group_accept;
    assign station_addr_o = {st_upper_reg, st_lower_reg};
    assign phy_req_o = pending_reg;
    assign phy_write_o = write_sel_reg;
    assign phy_addr_o = phy_addr_reg;
    assign phy_reg_o = phy_index_reg;
    assign phy_wdata_o = mgmt_data_reg;

    // checks on the management sequence, register reads, soft reset and hash writes
    sequence mgmt_start_s;
        reg_wr_i && sel_ctl && reg_wdata_i[mac_filt_pkg::CTL_PEND_BIT] && !pending_reg;
    endsequence
    sequence read_done_s;
        pending_reg && !write_sel_reg && phy_done_i;
    endsequence

    pend_start_a: assert property (mgmt_start_s |=> pending_reg && phy_req_o)
        else $error("pending bit not set on start");
    pend_hold_a: assert property (pending_reg && !phy_done_i |=> pending_reg)
        else $error("pending bit dropped before phy answer");
    read_capture_a: assert property (read_done_s |=>
        !pending_reg && mgmt_data_reg == $past(phy_rdata_i))
        else $error("phy read data not captured at completion");
    write_keep_a: assert property (pending_reg && write_sel_reg |=>
        $stable(phy_wdata_o) && phy_write_o)
        else $error("write data changed during write cycle");
    reg_index_a: assert property (mgmt_start_s |=>
        phy_reg_o == $past(reg_wdata_i[10:6]) && phy_write_o == $past(reg_wdata_i[1]))
        else $error("phy index or direction not taken");
    rd_upper_a: assert property (reg_rd_i && sel_st_up |=>
        reg_rdata_o == {16'h0000, $past(st_upper_reg)})
        else $error("upper address read wrong");
    rd_once_a: assert property (reg_rd_i ##1 !reg_rd_i |=> reg_rdata_o == 32'h0000_0000)
        else $error("read data stood longer than one cycle");
    prot_keep_a: assert property (soft_reset_i && reset_protect_i && !reg_wr_i |=>
        $stable(station_addr_o))
        else $error("protected address changed on soft reset");
    prot_clear_a: assert property (soft_reset_i && !reset_protect_i |=>
        station_addr_o == {mac_filt_pkg::STATION_UPPER_RST, mac_filt_pkg::STATION_LOWER_RST})
        else $error("address not restored on unprotected soft reset");
    hash_write_a: assert property (reg_wr_i && sel_hash_lo && !soft_reset_i |=>
        hash_lower_reg == $past(reg_wdata_i))
        else $error("hash low word write lost");
endmodule : mac_addr_filter_phy_mgmt

// >>> phy_model.sv
// behavioural internal phy: answers management accesses after a chosen delay
module phy_model (
    // clock and reset
    input wire logic clk_i,
    input wire logic rst_n_i,
    // management request from the block, and the answer delay from the bench
    input wire logic req_i,
    input wire logic write_i,
    input wire logic [4:0] reg_i,
    input wire logic [15:0] wdata_i,
    input wire logic [3:0] delay_i,
    // completion back to the block
    output logic done_o,
    output logic [15:0] rdata_o
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [15:0] regs [32]; // phy register file
    logic [3:0] wait_reg; // cycles left before answering
    logic served_reg; // access answered, wait for the request to drop
    initial for (int i = 0; i < 32; i++) regs[i] = 16'h0000;
    // one answer per request; the data line toggles outside done so stale data is never seen
    always @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            done_o <= 1'b0;
            rdata_o <= 16'h0000;
            wait_reg <= 4'h0;
            served_reg <= 1'b0;
        end else begin
            done_o <= 1'b0;
            rdata_o <= ~rdata_o;
            if (!req_i) begin
                served_reg <= 1'b0;
                wait_reg <= delay_i;
            end else if (!served_reg && wait_reg != 4'h0) begin
                wait_reg <= wait_reg - 4'h1;
            end else if (!served_reg) begin
                done_o <= 1'b1;
                served_reg <= 1'b1;
                if (write_i) regs[reg_i] <= wdata_i;
                else rdata_o <= regs[reg_i];
            end
        end
    end
endmodule : phy_model

// >>> mac_addr_filter_phy_mgmt_test.sv
// self-checking bench for the station address, hash filter and phy management block
module mac_addr_filter_phy_mgmt_test;
    timeunit 1ns;
    timeprecision 1ps;
    logic core_clk_i = 1'b0;
    logic rst_n_i = 1'b0;
    logic [11:0] reg_addr_i = 12'h000;
    logic [31:0] reg_wdata_i = 32'h0000_0000;
    logic reg_wr_i = 1'b0;
    logic reg_rd_i = 1'b0;
    logic soft_reset_i = 1'b0;
    logic reset_protect_i = 1'b0;
    logic rx_start_i = 1'b0;
    logic rx_valid_i = 1'b0;
    logic [7:0] rx_byte_i = 8'h00;
    logic [31:0] reg_rdata_o;
    logic verdict_valid_o, station_hit_o, group_frame_o, group_accept_o;
    logic [47:0] station_addr_o;
    logic phy_req_o, phy_write_o, phy_done_i;
    logic [4:0] phy_addr_o, phy_reg_o;
    logic [15:0] phy_wdata_o, phy_rdata_i;
    logic [3:0] phy_delay = 4'h0; // answer delay of the phy model
    logic [31:0] rnd = 32'h0000_0044; // lfsr state, seed 68
    int mismatches = 0;
    int tests_run = 0;
    int cycles = 0;
    mac_addr_filter_phy_mgmt u_mac_addr_filter_phy_mgmt (
        .core_clk_i(core_clk_i), .rst_n_i(rst_n_i), .reg_addr_i(reg_addr_i),
        .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i),
        .reg_rdata_o(reg_rdata_o), .soft_reset_i(soft_reset_i),
        .reset_protect_i(reset_protect_i), .rx_start_i(rx_start_i),
        .rx_valid_i(rx_valid_i), .rx_byte_i(rx_byte_i), .verdict_valid_o(verdict_valid_o),
        .station_hit_o(station_hit_o), .group_frame_o(group_frame_o),
        .group_accept_o(group_accept_o), .station_addr_o(station_addr_o),
        .phy_req_o(phy_req_o), .phy_write_o(phy_write_o), .phy_addr_o(phy_addr_o),
        .phy_reg_o(phy_reg_o), .phy_wdata_o(phy_wdata_o), .phy_done_i(phy_done_i),
        .phy_rdata_i(phy_rdata_i));
    phy_model u_phy_model (
        .clk_i(core_clk_i), .rst_n_i(rst_n_i), .req_i(phy_req_o), .write_i(phy_write_o),
        .reg_i(phy_reg_o), .wdata_i(phy_wdata_o), .delay_i(phy_delay),
        .done_o(phy_done_i), .rdata_o(phy_rdata_i));
    // 125 MHz clock
    always #4 core_clk_i = ~core_clk_i;
    // hang guard, far above the few hundred cycles the run needs
    always @(posedge core_clk_i) begin
        cycles++;
        if (cycles == 20000) begin
            mismatches++;
            close_out();
        end
    end
    // next pseudo-random word
    function automatic logic [31:0] lfsr(input logic [31:0] x);
        return {x[30:0], 1'b0} ^ (x[31] ? 32'h04C1_1DB7 : 32'h0000_0000);
    endfunction : lfsr
    // hash index: reflected crc over the six octets, first octet lsb first
    function automatic logic [5:0] hidx(input logic [47:0] a);
        logic [31:0] c;
        c = mac_filt_pkg::CRC_INIT;
        for (int i = 0; i < 48; i++) begin
            c = (c[0] ^ a[i]) ? ((c >> 1) ^ mac_filt_pkg::CRC_POLY) : (c >> 1);
        end
        return c[31:26];
    endfunction : hidx
    // count a comparison, report a mismatch at once
    task automatic chk(input logic [63:0] got, input logic [63:0] exp);
        tests_run++;
        if (got !== exp) begin
            mismatches++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk
    // one-cycle register write
    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        @(posedge core_clk_i);
        reg_addr_i <= a;
        reg_wdata_i <= d;
        reg_wr_i <= 1'b1;
        @(posedge core_clk_i);
        reg_wr_i <= 1'b0;
        #1;
    endtask : wr
    // one-cycle register read; data is taken in the single cycle it stands
    task automatic rc(input logic [11:0] a, input logic [31:0] e);
        @(posedge core_clk_i);
        reg_addr_i <= a;
        reg_rd_i <= 1'b1;
        @(posedge core_clk_i);
        reg_rd_i <= 1'b0;
        #1;
        chk(reg_rdata_o, e);
    endtask : rc
    // wait for the pending bit to drop, bounded
    task automatic poll();
        for (int i = 0; i < 40; i++) begin
            @(posedge core_clk_i);
            reg_addr_i <= 12'h114;
            reg_rd_i <= 1'b1;
            @(posedge core_clk_i);
            reg_rd_i <= 1'b0;
            #1;
            if (reg_rdata_o[0] === 1'b0) return;
        end
        chk(64'h1, 64'h0);
    endtask : poll
    // six destination octets, then expect the verdict pulse
    task automatic send(input logic [47:0] a);
        for (int i = 0; i < 6; i++) begin
            @(posedge core_clk_i);
            rx_valid_i <= 1'b1;
            rx_start_i <= (i == 0);
            rx_byte_i <= a[8*i +: 8];
        end
        @(posedge core_clk_i);
        rx_valid_i <= 1'b0;
        rx_start_i <= 1'b0;
        #1;
        chk(verdict_valid_o, 1'b1);
    endtask : send
    // verdict and end of run
    task automatic close_out();
        if (mismatches == 0 && tests_run > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask : close_out
    // main sequence
    initial begin
        logic [47:0] st, a;
        logic [63:0] ht;
        logic [15:0] pd;
        logic [4:0] ix;
        repeat (5) @(posedge core_clk_i);
        rst_n_i <= 1'b1;
        repeat (3) @(posedge core_clk_i);
        // reset values, plus an unmapped hole that reads zero
        rc(12'h104, 32'h0000_FFFF);
        rc(12'h108, 32'hFFFF_FFFF);
        rc(12'h10C, 32'h0000_0000);
        rc(12'h110, 32'h0000_0000);
        rc(12'h118, 32'h0000_0000);
        rc(12'h200, 32'h0000_0000);
        // station address; junk in the reserved half must not read back
        rnd = lfsr(rnd);
        st[31:0] = rnd;
        rnd = lfsr(rnd);
        st[47:32] = rnd[15:0];
        wr(12'h104, {~rnd[31:16], st[47:32]});
        wr(12'h108, st[31:0]);
        rc(12'h104, {16'h0000, st[47:32]});
        rc(12'h108, st[31:0]);
        chk(station_addr_o, st);
        send(st);
        chk(station_hit_o, 1'b1);
        send({st[39:0], st[47:40]}); // same octets, wrong order
        chk(station_hit_o, 1'b0);
        // random hash table, random group addresses, then accept-all over an empty table
        rnd = lfsr(rnd);
        ht[63:32] = rnd;
        rnd = lfsr(rnd);
        ht[31:0] = rnd;
        wr(12'h10C, ht[63:32]);
        wr(12'h110, ht[31:0]);
        rc(12'h10C, ht[63:32]);
        for (int i = 0; i < 14; i++) begin
            if (i == 12) begin
                ht = 64'h0;
                wr(12'h10C, 32'h0000_0000);
                wr(12'h110, 32'h0000_0000);
                wr(12'h180, 32'h0000_0001);
            end
            rnd = lfsr(rnd);
            a = {rnd[15:0], lfsr(rnd)};
            a[0] = 1'b1;
            send(a);
            chk(group_frame_o, 1'b1);
            chk(group_accept_o, (i >= 12) | ht[hidx(a)]);
        end
        // soft reset with and without protection of the station address
        for (int p = 1; p >= 0; p--) begin
            reset_protect_i <= p[0];
            @(posedge core_clk_i);
            soft_reset_i <= 1'b1;
            @(posedge core_clk_i);
            soft_reset_i <= 1'b0;
            rc(12'h108, p[0] ? st[31:0] : 32'hFFFF_FFFF);
            rc(12'h104, p[0] ? {16'h0000, st[47:32]} : 32'h0000_FFFF);
            rc(12'h180, 32'h0000_0000);
        end
        // phy write then read back, prompt and slow phy
        for (int i = 0; i < 4; i++) begin
            rnd = lfsr(rnd);
            ix = rnd[4:0];
            pd = rnd[20:5];
            phy_delay <= i[0] ? 4'hF : 4'h0;
            poll();
            wr(12'h118, {16'h0000, pd});
            wr(12'h114, {16'h0000, 5'h01, ix, 6'b000011});
            chk({phy_req_o, phy_write_o, phy_addr_o, phy_reg_o, phy_wdata_o},
                {1'b1, 1'b1, 5'h01, ix, pd});
            if (i[0]) wr(12'h118, {16'h0000, ~pd}); // dropped while pending
            poll();
            rc(12'h118, {16'h0000, pd});
            wr(12'h118, 32'h0000_0000);
            wr(12'h114, {16'h0000, 5'h01, ix, 6'b000001});
            chk({phy_req_o, phy_write_o, phy_reg_o}, {1'b1, 1'b0, ix});
            poll();
            rc(12'h114, {16'h0000, 5'h01, ix, 6'b000000});
            rc(12'h118, {16'h0000, pd});
        end
        close_out();
    end
endmodule : mac_addr_filter_phy_mgmt_test
